// file: rtl/bid_pkg.sv
// constants and types shared by the binary increment/decrement unit
package bid_pkg;
   // instruction function codes
   localparam logic [9:0] FC_INC16 = 10'd590;
   localparam logic [9:0] FC_INC32 = 10'd591;
   localparam logic [9:0] FC_DEC16 = 10'd592;
   localparam logic [9:0] FC_DEC32 = 10'd593;

   // apb register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_INT_STAT = 12'h008;
   localparam logic [11:0] OFS_INT_MASK = 12'h00C;
   localparam logic [11:0] OFS_LAST_RES = 12'h010;
   localparam logic [11:0] OFS_OP_COUNT = 12'h014;

   // control register fields
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RESET = 1'b1;

   // status register fields
   localparam int ST_ERR_BIT = 0;
   localparam int ST_ZERO_BIT = 1;
   localparam int ST_ROLL_BIT = 2;
   localparam int ST_NEG_BIT = 3;
   localparam int ST_BUSY_BIT = 4;

   // interrupt status and mask fields
   localparam int EV_W = 4;
   localparam int EV_DONE_BIT = 0;
   localparam int EV_ZERO_BIT = 1;
   localparam int EV_ROLL_BIT = 2;
   localparam int EV_REFUSE_BIT = 3;
   localparam logic [EV_W-1:0] INT_MASK_RESET = 4'h0;

   // operand geometry
   localparam int WORD_W = 16;
   localparam int DWORD_W = 32;
   localparam int DIGIT_W = 4;
   localparam int NEG_BIT = 15;

   typedef enum {
      S_IDLE,
      S_RD_LO,
      S_RD_HI,
      S_CALC,
      S_EXEC,
      S_WR_LO,
      S_WR_HI,
      S_DONE
   } bid_state_t;
endpackage

// file: rtl/bid_arith.sv
// combinational plus/minus one with per-digit roll detection
`timescale 1ns/1ns
module bid_arith
(
   input wire logic [31:0] operand, // upper word in 31:16, addressed word in 15:0
   input wire logic is_dec, // 1 subtracts one, 0 adds one
   input wire logic is_wide, // 1 works on all 32 bits
   output logic [31:0] result, // wrapped result, upper half zero for 16-bit
   output logic zero, // result is all zeros
   output logic roll, // some hex digit rolled over
   output logic neg // bit 15 of the result's upper word for 32-bit, bit 15 of the result for 16-bit
);
   localparam int NDIG = bid_pkg::DWORD_W / bid_pkg::DIGIT_W;
   localparam int NDIG16 = bid_pkg::WORD_W / bid_pkg::DIGIT_W;

   logic [31:0] src;
   logic [31:0] sum;
   logic [NDIG-1:0] dig_roll;

   always_comb
   begin
      src = is_wide ? operand : {16'h0000, operand[15:0]};
      // wraps modulo the width, no saturation
      sum = is_dec ? src - 32'h0000_0001 : src + 32'h0000_0001;
      result = is_wide ? sum : {16'h0000, sum[15:0]};
   end

   genvar g;
   generate
      for (g = 0; g < NDIG; g++)
      begin : g_digit
         localparam int LO = g * bid_pkg::DIGIT_W;
         localparam logic IN16 = (g < NDIG16);
         always_comb
         begin
            if (!is_wide && !IN16)
            begin
               dig_roll[g] = 1'b0;
            end
            else if (is_dec)
            begin
               dig_roll[g] = (src[LO+:4] == 4'h0) && (result[LO+:4] == 4'hF);
            end
            else
            begin
               dig_roll[g] = (src[LO+:4] == 4'hF) && (result[LO+:4] == 4'h0);
            end
         end
      end
   endgenerate

   always_comb
   begin
      zero = (result == 32'h0000_0000);
      roll = |dig_roll;
      // the sign sits in the upper word for the 32-bit forms
      neg = is_wide ? result[bid_pkg::NEG_BIT+16] : result[bid_pkg::NEG_BIT];
   end
endmodule // bid_arith

// file: rtl/bid_edge.sv
// remembers the execution condition of each instruction slot to find off-to-on edges
`timescale 1ns/1ns
module bid_edge
#(
   parameter int SLOTS = 16, // instruction instances tracked
   parameter int SLOT_W = 4 // width of the slot index
)
(
   input wire logic sys_clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic sample, // one-cycle pulse: this slot is scanned now
   input wire logic [SLOT_W-1:0] slot, // slot being scanned
   input wire logic cond, // its execution condition
   output logic rise // cond on now, off at the previous scan of this slot
);
   logic [SLOTS-1:0] prev_q;
   logic [SLOTS-1:0] prev_d;

   always_comb
   begin
      rise = cond && !prev_q[slot];
   end

   genvar g;
   generate
      for (g = 0; g < SLOTS; g++)
      begin : g_slot
         always_comb
         begin
            prev_d[g] = (sample && (slot == SLOT_W'(g))) ? cond : prev_q[g];
         end
      end
   endgenerate

   // a slot never scanned counts as off, so a first scan with the condition on is an edge
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         prev_q <= '0;
      end
      else
      begin
         prev_q <= prev_d;
      end
   end
endmodule // bid_edge

// file: rtl/bid_top.sv
// binary increment/decrement datapath with operand memory port and apb registers
`timescale 1ns/1ns

// Notes on behaviour
// - codes 590 and 591 add one to a word and a word pair.
// - codes 592 and 593 subtract one from a word and a word pair.
// - 32-bit add: next word is upper half, addressed word lower half.
// - 32-bit subtract uses the same upper and lower word pairing.
// - zero flag set when the whole result is zero, else cleared.
// - increment sets roll flag when any hex digit goes F to 0.
// - decrement sets roll flag when any hex digit goes 0 to F.
// - negative flag follows bit 15 of the result's upper word for a word pair, of the word itself for a single word.
// - level add form adds one on every scan while condition is on.
// - level subtract form subtracts one every scan while condition is on.
// - edge add form acts only when condition went from off to on.
// - edge subtract form acts only when condition went from off to on.
module bid_top
#(
   parameter int SLOTS = 16, // instruction instances with edge memory
   parameter int SLOT_W = 4, // slot index width
   parameter int ADDR_W = 16 // operand memory word address width
)
(
   input wire logic sys_clk, // system clock, 100 MHz
   input wire logic rst_b, // synchronous reset, active low
   // instruction sequencer
   input wire logic req_valid, // one scan of an instruction is offered
   output logic req_ready, // block idle, request taken when valid
   input wire logic [9:0] req_func, // function code
   input wire logic req_up_diff, // edge form of the instruction
   input wire logic req_cond, // execution condition
   input wire logic [SLOT_W-1:0] req_slot, // instruction instance
   input wire logic [ADDR_W-1:0] req_addr, // address of the target word
   output logic exec_done, // one-cycle pulse, request finished
   output logic exec_ran, // with exec_done: operand was changed
   output logic error_flag, // condition flag, error
   output logic zero_result_flag, // condition flag, equals
   output logic digit_roll_flag, // condition flag, carry
   output logic negative_flag, // condition flag, negative
   // operand word memory, read data one cycle after mem_rd
   output logic mem_rd, // read strobe
   output logic mem_wr, // write strobe
   output logic [ADDR_W-1:0] mem_addr, // word address
   output logic [15:0] mem_wdata, // write data
   input wire logic [15:0] mem_rdata, // read data
   // apb slave
   input wire logic psel, // select
   input wire logic penable, // access phase
   input wire logic pwrite, // write
   input wire logic [11:0] paddr, // byte address
   input wire logic [31:0] pwdata, // write data
   output logic [31:0] prdata, // read data
   output logic pready, // transfer complete
   output logic pslverr, // unmapped address
   output logic irq // level, unmasked event pending
);
   bid_pkg::bid_state_t state_q;
   bid_pkg::bid_state_t state_d;
   logic [9:0] func_q, func_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [31:0] opnd_q, opnd_d;
   logic [31:0] res_q, res_d;
   logic ready_q, ready_d;
   logic done_q, done_d;
   logic ran_q, ran_d;
   logic err_q, err_d;
   logic zero_q, zero_d;
   logic roll_q, roll_d;
   logic neg_q, neg_d;
   logic mrd_q, mrd_d;
   logic mwr_q, mwr_d;
   logic [ADDR_W-1:0] maddr_q, maddr_d;
   logic [15:0] mwdata_q, mwdata_d;
   logic [bid_pkg::EV_W-1:0] ev;

   logic en_q, en_d;
   logic [bid_pkg::EV_W-1:0] istat_q, istat_d;
   logic [bid_pkg::EV_W-1:0] imask_q, imask_d;
   logic [31:0] count_q, count_d;
   logic [31:0] prdata_q, prdata_d;
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic irq_q, irq_d;

   logic take;
   logic rise;
   logic legal;
   logic is_dec;
   logic is_wide;
   logic [31:0] a_res;
   logic a_zero, a_roll, a_neg;

   assign take = req_valid && ready_q;

   bid_edge #(
      .SLOTS(SLOTS),
      .SLOT_W(SLOT_W)
   ) u_edge (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .sample(take),
      .slot(req_slot),
      .cond(req_cond),
      .rise(rise)
   );

   always_comb
   begin
      is_dec = (func_q == bid_pkg::FC_DEC16) || (func_q == bid_pkg::FC_DEC32);
      is_wide = (func_q == bid_pkg::FC_INC32) || (func_q == bid_pkg::FC_DEC32);
      legal = (req_func == bid_pkg::FC_INC16) || (req_func == bid_pkg::FC_INC32) ||
              (req_func == bid_pkg::FC_DEC16) || (req_func == bid_pkg::FC_DEC32);
   end

   bid_arith u_arith (
      .operand(opnd_q),
      .is_dec(is_dec),
      .is_wide(is_wide),
      .result(a_res),
      .zero(a_zero),
      .roll(a_roll),
      .neg(a_neg)
   );

   // sequencer side: read operand, compute, write back, report
   always_comb
   begin
      state_d = state_q;
      func_d = func_q;
      addr_d = addr_q;
      opnd_d = opnd_q;
      res_d = res_q;
      ran_d = ran_q;
      err_d = err_q;
      zero_d = zero_q;
      roll_d = roll_q;
      neg_d = neg_q;
      mrd_d = 1'b0;
      mwr_d = 1'b0;
      maddr_d = maddr_q;
      mwdata_d = mwdata_q;
      ev = '0;
      case (state_q)
         bid_pkg::S_IDLE:
         begin
            if (take)
            begin
               func_d = req_func;
               addr_d = req_addr;
               // a scan that does not execute leaves operand and flags untouched
               if (en_q && legal && (req_up_diff ? rise : req_cond))
               begin
                  state_d = bid_pkg::S_RD_LO;
                  mrd_d = 1'b1;
                  maddr_d = req_addr;
                  ran_d = 1'b1;
               end
               else
               begin
                  state_d = bid_pkg::S_DONE;
                  ran_d = 1'b0;
                  ev[bid_pkg::EV_REFUSE_BIT] = !en_q || !legal;
               end
            end
         end
         bid_pkg::S_RD_LO:
         begin
            if (is_wide)
            begin
               state_d = bid_pkg::S_RD_HI;
               mrd_d = 1'b1;
               maddr_d = ADDR_W'(addr_q + 1'b1);
            end
            else
            begin
               state_d = bid_pkg::S_CALC;
            end
         end
         bid_pkg::S_RD_HI:
         begin
            opnd_d[15:0] = mem_rdata;
            state_d = bid_pkg::S_CALC;
         end
         bid_pkg::S_CALC:
         begin
            if (is_wide)
            begin
               opnd_d[31:16] = mem_rdata;
            end
            else
            begin
               opnd_d = {16'h0000, mem_rdata};
            end
            state_d = bid_pkg::S_EXEC;
         end
         bid_pkg::S_EXEC:
         begin
            res_d = a_res;
            err_d = 1'b0;
            zero_d = a_zero;
            roll_d = a_roll;
            neg_d = a_neg;
            ev[bid_pkg::EV_ZERO_BIT] = a_zero;
            ev[bid_pkg::EV_ROLL_BIT] = a_roll;
            state_d = bid_pkg::S_WR_LO;
            mwr_d = 1'b1;
            maddr_d = addr_q;
            mwdata_d = a_res[15:0];
         end
         bid_pkg::S_WR_LO:
         begin
            if (is_wide)
            begin
               state_d = bid_pkg::S_WR_HI;
               mwr_d = 1'b1;
               maddr_d = ADDR_W'(addr_q + 1'b1);
               mwdata_d = res_q[31:16];
            end
            else
            begin
               state_d = bid_pkg::S_DONE;
            end
         end
         bid_pkg::S_WR_HI:
         begin
            state_d = bid_pkg::S_DONE;
         end
         bid_pkg::S_DONE:
         begin
            ev[bid_pkg::EV_DONE_BIT] = ran_q;
            state_d = bid_pkg::S_IDLE;
         end
         default:
         begin
            state_d = bid_pkg::S_IDLE;
         end
      endcase
      ready_d = (state_d == bid_pkg::S_IDLE);
      done_d = (state_d == bid_pkg::S_DONE);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         state_q <= bid_pkg::S_IDLE;
         func_q <= '0;
         addr_q <= '0;
         opnd_q <= 32'h0000_0000;
         res_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         done_q <= 1'b0;
         ran_q <= 1'b0;
         err_q <= 1'b0;
         zero_q <= 1'b0;
         roll_q <= 1'b0;
         neg_q <= 1'b0;
         mrd_q <= 1'b0;
         mwr_q <= 1'b0;
         maddr_q <= '0;
         mwdata_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         func_q <= func_d;
         addr_q <= addr_d;
         opnd_q <= opnd_d;
         res_q <= res_d;
         ready_q <= ready_d;
         done_q <= done_d;
         ran_q <= ran_d;
         err_q <= err_d;
         zero_q <= zero_d;
         roll_q <= roll_d;
         neg_q <= neg_d;
         mrd_q <= mrd_d;
         mwr_q <= mwr_d;
         maddr_q <= maddr_d;
         mwdata_q <= mwdata_d;
      end
   end

   // apb registers; pready comes one cycle after setup, so every access has no wait state
   always_comb
   begin
      en_d = en_q;
      imask_d = imask_q;
      count_d = count_q;
      prdata_d = prdata_q;
      pslverr_d = 1'b0;
      pready_d = psel && !penable && !pready_q;
      // hardware set wins over a same-cycle write-one-to-clear
      istat_d = istat_q | ev;
      if (ev[bid_pkg::EV_DONE_BIT])
      begin
         count_d = count_q + 32'h0000_0001;
      end
      if (psel && !penable)
      begin
         prdata_d = 32'h0000_0000;
         case (paddr)
            bid_pkg::OFS_CTRL: prdata_d[bid_pkg::CTRL_EN_BIT] = en_q;
            bid_pkg::OFS_STATUS:
            begin
               prdata_d[bid_pkg::ST_ERR_BIT] = err_q;
               prdata_d[bid_pkg::ST_ZERO_BIT] = zero_q;
               prdata_d[bid_pkg::ST_ROLL_BIT] = roll_q;
               prdata_d[bid_pkg::ST_NEG_BIT] = neg_q;
               prdata_d[bid_pkg::ST_BUSY_BIT] = !ready_q;
            end
            bid_pkg::OFS_INT_STAT: prdata_d[bid_pkg::EV_W-1:0] = istat_q;
            bid_pkg::OFS_INT_MASK: prdata_d[bid_pkg::EV_W-1:0] = imask_q;
            bid_pkg::OFS_LAST_RES: prdata_d = res_q;
            bid_pkg::OFS_OP_COUNT: prdata_d = count_q;
            default: pslverr_d = 1'b1;
         endcase
      end
      else if (psel && penable && pready_q)
      begin
         pslverr_d = pslverr_q;
         if (pwrite)
         begin
            case (paddr)
               bid_pkg::OFS_CTRL: en_d = pwdata[bid_pkg::CTRL_EN_BIT];
               bid_pkg::OFS_INT_STAT: istat_d = (istat_q & ~pwdata[bid_pkg::EV_W-1:0]) | ev;
               bid_pkg::OFS_INT_MASK: imask_d = pwdata[bid_pkg::EV_W-1:0];
               default: en_d = en_q;
            endcase
         end
      end
      irq_d = |(istat_d & imask_d);
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         en_q <= bid_pkg::CTRL_EN_RESET;
         istat_q <= '0;
         imask_q <= bid_pkg::INT_MASK_RESET;
         count_q <= 32'h0000_0000;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         en_q <= en_d;
         istat_q <= istat_d;
         imask_q <= imask_d;
         count_q <= count_d;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         irq_q <= irq_d;
      end
   end

   assign req_ready = ready_q;
   assign exec_done = done_q;
   assign exec_ran = ran_q;
   assign error_flag = err_q;
   assign zero_result_flag = zero_q;
   assign digit_roll_flag = roll_q;
   assign negative_flag = neg_q;
   assign mem_rd = mrd_q;
   assign mem_wr = mwr_q;
   assign mem_addr = maddr_q;
   assign mem_wdata = mwdata_q;
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign irq = irq_q;
endmodule // bid_top

// file: verif/bid_chk.sv
// assertion checker for the binary increment/decrement unit
`timescale 1ns/1ns
module bid_chk
(
   input wire logic sys_clk, // clock
   input wire logic rst_b, // reset, active low
   input wire logic req_valid, // offer
   input wire logic req_ready, // idle
   input wire logic [9:0] req_func, // code
   input wire logic req_up_diff, // edge form
   input wire logic req_cond, // condition
   input wire logic exec_done, // finished
   input wire logic exec_ran, // operand changed
   input wire logic error_flag, // error
   input wire logic zero_result_flag, // equals
   input wire logic digit_roll_flag, // carry
   input wire logic negative_flag, // negative
   input wire logic mem_rd, // read strobe
   input wire logic mem_wr, // write strobe
   input wire logic [15:0] mem_wdata, // write data
   input wire logic [15:0] mem_rdata // read data
);
   logic rd_q, wr_q, wide_q, dec_q;
   logic [31:0] w_q, e32;
   logic [15:0] e16;
   logic [3:0] lo4;
   wire take = req_valid && req_ready;
   wire legal = req_func >= bid_pkg::FC_INC16 && req_func <= bid_pkg::FC_DEC32;
   // read words shift in from the top: narrow lands in 31:16, wide ends as {high, low}
   always_ff @(posedge sys_clk)
   begin
      rd_q <= mem_rd;
      wr_q <= mem_wr;
      w_q <= rd_q ? {mem_rdata, w_q[31:16]} : w_q;
      wide_q <= take ? (req_func == bid_pkg::FC_INC32 || req_func == bid_pkg::FC_DEC32) : wide_q;
      dec_q <= take ? (req_func == bid_pkg::FC_DEC16 || req_func == bid_pkg::FC_DEC32) : dec_q;
   end
   always_comb
   begin
      e32 = dec_q ? w_q - 32'h1 : w_q + 32'h1;
      e16 = dec_q ? w_q[31:16] - 16'h1 : w_q[31:16] + 16'h1;
      lo4 = wide_q ? w_q[3:0] : w_q[19:16];
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_inc16; mem_wr && !wide_q && !dec_q |-> mem_wdata == e16; endproperty
   a_inc16: assert property (p_inc16) else $error("narrow add wrote a wrong word");
   property p_dec16; mem_wr && !wide_q && dec_q |-> mem_wdata == e16; endproperty
   a_dec16: assert property (p_dec16) else $error("narrow subtract wrote a wrong word");
   property p_wide_lo; mem_wr && wide_q && !wr_q |-> mem_wdata == e32[15:0] ##1 mem_wr; endproperty
   a_wide_lo: assert property (p_wide_lo) else $error("wide low word wrong");
   property p_wide_hi; mem_wr && wide_q && wr_q |-> mem_wdata == e32[31:16]; endproperty
   a_wide_hi: assert property (p_wide_hi) else $error("wide high word wrong");
   property p_zero; exec_done && exec_ran |-> zero_result_flag == (wide_q ? e32 == 32'h0 : e16 == 16'h0); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_roll; exec_done && exec_ran |-> digit_roll_flag == (lo4 == (dec_q ? 4'h0 : 4'hF)); endproperty
   a_roll: assert property (p_roll) else $error("roll flag wrong");
   property p_neg; exec_done && exec_ran |-> negative_flag == $past(mem_wdata[15]); endproperty
   a_neg: assert property (p_neg) else $error("negative flag wrong");
   wire wide_req = req_func == bid_pkg::FC_INC32 || req_func == bid_pkg::FC_DEC32;
   // a narrow run ends five cycles after its take edge, a wide run seven, so each gets its own delay
   property p_level;
      take && legal && !req_up_diff && req_cond && !wide_req |-> ##5 exec_done && exec_ran;
   endproperty
   a_level: assert property (p_level) else $error("narrow level form did not run in time");
   property p_level_wide;
      take && legal && !req_up_diff && req_cond && wide_req |-> ##7 exec_done && exec_ran;
   endproperty
   a_level_wide: assert property (p_level_wide) else $error("wide level form did not run in time");
   property p_skip; take && !req_cond |-> ##1 exec_done && !exec_ran; endproperty
   a_skip: assert property (p_skip) else $error("scan with condition off changed operand");
   property p_err; !error_flag; endproperty
   a_err: assert property (p_err) else $error("error flag set");
endmodule // bid_chk

bind bid_top bid_chk chk
(
   .sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
   .req_up_diff(req_up_diff), .req_cond(req_cond), .exec_done(exec_done), .exec_ran(exec_ran),
   .error_flag(error_flag), .zero_result_flag(zero_result_flag), .digit_roll_flag(digit_roll_flag),
   .negative_flag(negative_flag), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata)
);

// file: verif/bid_mem.sv
// operand word memory beside the unit, one-cycle read latency
`timescale 1ns/1ns
module bid_mem
(
   input wire logic sys_clk, // clock
   input wire logic mem_rd, // read strobe
   input wire logic mem_wr, // write strobe
   input wire logic [15:0] mem_addr, // word address
   input wire logic [15:0] mem_wdata, // write data
   output logic [15:0] mem_rdata // read data
);
   logic [15:0] mem_q [0:255];
   initial mem_rdata = 16'h0000;
   // outside the read slot the bus toggles so a late sample cannot match by luck
   always @(posedge sys_clk)
   begin
      if (mem_wr)
      begin
         mem_q[mem_addr[7:0]] <= mem_wdata;
      end
      mem_rdata <= mem_rd ? mem_q[mem_addr[7:0]] : ~mem_rdata;
   end
endmodule // bid_mem

// file: verif/tb_bid_top.sv
// self-checking bench for the binary increment/decrement unit
`timescale 1ns/1ns
module tb_bid_top;
   typedef struct {logic ran; logic [7:0] a; logic w; logic [31:0] v; logic [3:0] f;} bid_exp_t;
   logic sys_clk, rst_b, req_valid, req_up_diff, req_cond, psel, penable, pwrite;
   logic req_ready, exec_done, exec_ran, error_flag, zero_result_flag, digit_roll_flag, negative_flag;
   logic mem_rd, mem_wr, pready, pslverr, irq;
   logic [9:0] req_func;
   logic [3:0] req_slot, fl;
   logic [15:0] req_addr, mem_addr, mem_wdata, mem_rdata;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed;
   logic [15:0] sh [0:255];
   logic pv [0:15];
   bid_exp_t eq [$];
   bid_exp_t me;
   logic [32:0] aq [$];
   int n_mismatch, n_compared, cyc;
   logic [9:0] tf [9] = '{10'd590, 10'd592, 10'd590, 10'd592, 10'd591, 10'd593, 10'd591, 10'd593, 10'd590};
   logic [31:0] tv [9] = '{32'hFFFF, 32'h0, 32'h7FFF, 32'h1, 32'hFFFF, 32'h10000, 32'hFFFFFFFF, 32'h0, 32'h1234};

   bid_top dut
   (
      .sys_clk(sys_clk), .rst_b(rst_b), .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
      .req_up_diff(req_up_diff), .req_cond(req_cond), .req_slot(req_slot), .req_addr(req_addr),
      .exec_done(exec_done), .exec_ran(exec_ran), .error_flag(error_flag), .zero_result_flag(zero_result_flag),
      .digit_roll_flag(digit_roll_flag), .negative_flag(negative_flag), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq(irq)
   );
   bid_mem mem
   (
      .sys_clk(sys_clk), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata)
   );

   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // entered just after a rising edge; one idle edge at the end keeps strobes from doubling up
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] exp);
      aq.push_back(exp);
      apb(1'b0, a, 32'h0);
   endtask

   task automatic idle();
      while (eq.size() != 0) @(posedge sys_clk);
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic put(input logic [7:0] a, input logic [31:0] v);
      {sh[a + 8'd1], sh[a]} = v;
      {mem.mem_q[a + 8'd1], mem.mem_q[a]} = v;
   endtask

   task automatic op(input logic [9:0] f, input logic d, input logic c, input logic [3:0] s, input logic [7:0] a);
      logic w, dc, ok;
      logic [31:0] v, r;
      w = f == bid_pkg::FC_INC32 || f == bid_pkg::FC_DEC32;
      dc = f == bid_pkg::FC_DEC16 || f == bid_pkg::FC_DEC32;
      ok = f >= bid_pkg::FC_INC16 && f <= bid_pkg::FC_DEC32 && c && !(d && pv[s]);
      pv[s] = c;
      v = w ? {sh[a + 8'd1], sh[a]} : {16'h0000, sh[a]};
      r = dc ? v - 32'h1 : v + 32'h1;
      r[31:16] = w ? r[31:16] : 16'h0000;
      if (ok)
      begin
         fl = {w ? r[31] : r[15], v[3:0] == (dc ? 4'h0 : 4'hF), r == 32'h0, 1'b0};
         {sh[a + 8'd1], sh[a]} = w ? r : {sh[a + 8'd1], r[15:0]};
      end
      eq.push_back('{ok, a, w, r, fl});
      req_valid <= 1'b1;
      req_func <= f;
      req_up_diff <= d;
      req_cond <= c;
      req_slot <= s;
      req_addr <= {8'h00, a};
      @(posedge sys_clk);
      while (req_ready !== 1'b1) @(posedge sys_clk);
      req_valid <= 1'b0;
      @(posedge sys_clk);
   endtask

   always @(posedge sys_clk)
   begin
      cyc++;
      if (exec_done === 1'b1)
      begin
         me = eq.pop_front();
         chk({exec_ran, negative_flag, digit_roll_flag, zero_result_flag, error_flag}, {me.ran, me.f}, "flags");
         // the next request may already have moved the shadow of the neighbouring word, so a narrow run checks one word
         if (me.ran)
            chk(me.w ? {mem.mem_q[me.a + 8'd1], mem.mem_q[me.a]} : {16'h0000, mem.mem_q[me.a]}, me.v, "word");
      end
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, aq.pop_front(), "apb read");
      if (cyc == 6000)
      begin
         n_mismatch++;
         conclude();
      end
   end

   initial
   begin
      seed = 32'h9e05;
      {n_mismatch, n_compared, cyc} = '0;
      {rst_b, req_valid, req_up_diff, req_cond, psel, penable, pwrite, fl} = '0;
      {req_func, req_slot, req_addr, paddr, pwdata} = '0;
      for (int i = 0; i < 256; i++)
      begin
         sh[i] = 16'(rnd());
         mem.mem_q[i] = sh[i];
      end
      for (int i = 0; i < 16; i++) pv[i] = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      rd(bid_pkg::OFS_CTRL, 33'h0_0000_0001);
      rd(bid_pkg::OFS_INT_MASK, 33'h0_0000_0000);
      rd(12'h018, 33'h1_0000_0000);
      for (int i = 0; i < 9; i++)
      begin
         idle();
         put(8'd10, tv[i]);
         op(tf[i], 1'b0, 1'b1, 4'd0, 8'd10);
      end
      for (int k = 0; k < 4; k++)
         for (int j = 0; j < 5; j++)
            op(k[1] ? bid_pkg::FC_DEC16 : bid_pkg::FC_INC16, k[0], 5'b11011 >> j, 4'(k + 8), 8'd20);
      for (int i = 0; i < 60; i++)
         op(10'd588 + 10'(rnd() % 7), rnd() % 2, rnd() % 4 != 0, 4'(rnd() % 4), 8'(rnd() % 63));
      idle();
      rd(bid_pkg::OFS_STATUS, {29'h0, fl});
      apb(1'b1, bid_pkg::OFS_INT_STAT, 32'hF);
      op(10'd600, 1'b0, 1'b1, 4'd1, 8'd30);
      put(8'd30, 32'h1234);
      op(bid_pkg::FC_INC16, 1'b0, 1'b1, 4'd1, 8'd30);
      idle();
      chk(irq, 1'b0, "masked irq");
      rd(bid_pkg::OFS_INT_STAT, 33'h0_0000_0009);
      rd(bid_pkg::OFS_LAST_RES, 33'h0_0000_1235);
      apb(1'b1, bid_pkg::OFS_INT_MASK, 32'h8);
      @(posedge sys_clk);
      chk(irq, 1'b1, "unmasked irq");
      apb(1'b1, bid_pkg::OFS_INT_STAT, 32'h8);
      @(posedge sys_clk);
      chk(irq, 1'b0, "cleared irq");
      rd(bid_pkg::OFS_INT_STAT, 33'h0_0000_0001);
      conclude();
   end
endmodule // tb_bid_top
